// ===== logic/trace_param_map.vh
// constants for the trace parameter channel
`ifndef TRACE_PARAM_MAP_VH
`define TRACE_PARAM_MAP_VH
`define ERR_BIT            2
`define CMD_HI             7
`define CMD_LO             4
`define CMD_DRIVE_TRACE    4'h1
`define CMD_THY_TRACE      4'h2
`define CMD_PARAM_READ     4'h6
`define CONV_X1            2'h0
`define CONV_X10           2'h1
`define CONV_X100          2'h2
`define ERR_OUT_OF_RANGE   16'h0001
`define ERR_NOT_EXIST      16'h0002
`define ERR_CONSISTENCY    16'h0003
`define ERR_NOT_ALLOWED    16'h0004
`define DRV_RECORDS        50
`define DRV_FIELDS         16
`define THY_RECORDS        16
`define THY_FIELDS         5
`define PARAM_COUNT        64
`endif

// ===== logic/trace_store.v
// circular trace memory with freeze after a post-trip count
`timescale 1ns/100ps
`default_nettype none
module trace_store #(
   parameter RECORDS = 50,
   parameter FIELDS  = 16,
   parameter AW      = 6
) (
   // clock and reset
   input  wire                 mclk,
   input  wire                 rst_b,
   // capture side
   input  wire                 sample_stb,
   input  wire [FIELDS*16-1:0] sample_data,
   input  wire                 trip,
   input  wire [AW-1:0]        post_trip_count,
   input  wire                 rearm,
   // read side
   input  wire [AW-1:0]        rd_offset,
   input  wire [4:0]           rd_field,
   output reg  [15:0]          rd_data,
   output reg  [AW-1:0]        rd_wptr,
   output reg                  tripped
);
   reg [15:0]   mem [0:RECORDS*FIELDS-1];
   reg [AW-1:0] wptr_reg;
   reg [AW-1:0] post_reg;
   reg          frozen_reg;
   reg          tripped_reg;
   reg          trip_pend_reg;
   wire         accept    = sample_stb && !frozen_reg && !rearm;
   wire         trip_seen = trip || trip_pend_reg;
   integer      i;
   localparam [AW:0] REC_N = RECORDS;
   function [AW-1:0] wrap_add;
      input [AW-1:0] a;
      input [AW-1:0] b;
      reg   [AW:0]   s;
      begin
         s = {1'b0, a} + {1'b0, b};
         if (s >= REC_N)
            s = s - REC_N;
         wrap_add = s[AW-1:0];
      end
   endfunction
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wptr_reg      <= {AW{1'b0}};
         post_reg      <= {AW{1'b0}};
         frozen_reg    <= 1'b0;
         tripped_reg   <= 1'b0;
         trip_pend_reg <= 1'b0;
      end else begin
         // a trip between samples waits for the next sample; a new trip beats rearm
         trip_pend_reg <= (trip || trip_pend_reg) && !(accept && !tripped_reg) &&
                          !(rearm && !trip);
         if (rearm) begin
            frozen_reg  <= 1'b0;
            tripped_reg <= 1'b0;
         end else if (accept) begin
            wptr_reg <= wrap_add(wptr_reg, {{(AW-1){1'b0}}, 1'b1});
            if (!tripped_reg) begin
               // first sample at or after the trip is the trip record
               if (trip_seen) begin
                  tripped_reg <= 1'b1;
                  post_reg    <= post_trip_count;
                  if (post_trip_count == {AW{1'b0}})
                     frozen_reg <= 1'b1;
               end
            end else begin
               // stop once the post-trip budget is used up
               post_reg <= post_reg - {{(AW-1){1'b0}}, 1'b1};
               if (post_reg == {{(AW-1){1'b0}}, 1'b1})
                  frozen_reg <= 1'b1;
            end
         end
      end
   end
   always @(posedge mclk) begin
      if (accept) begin
         for (i = 0; i < FIELDS; i = i + 1)
            mem[wptr_reg*FIELDS+i] <= sample_data[i*16 +: 16];
      end
   end
   // oldest record sits at the write pointer
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 16'h0000;
         rd_wptr <= {AW{1'b0}};
         tripped <= 1'b0;
      end else begin
         rd_data <= mem[wrap_add(wptr_reg, rd_offset)*FIELDS + rd_field];
         rd_wptr <= wptr_reg;
         tripped <= tripped_reg;
      end
   end
endmodule
`default_nettype wire

// ===== logic/fieldbus_trace_param_channel.v
// parameter channel command interpreter with drive and thyristor trace reads
`timescale 1ns/100ps
`default_nettype none
`include "trace_param_map.vh"
module fieldbus_trace_param_channel #(
   parameter PARAMS = `PARAM_COUNT
) (
   // clock and reset
   input  wire         mclk,
   input  wire         rst_b,
   // request words, one telegram per req_stb
   input  wire         req_stb,
   input  wire [15:0]  req_op,
   input  wire [15:0]  req_index,
   // parameter table lookup, same clock
   output reg  [15:0]  param_addr,
   input  wire [15:0]  param_value,
   input  wire [3:0]   param_type,
   input  wire         param_negated,
   input  wire [1:0]   param_conv,
   input  wire         param_exists,
   input  wire         param_bus_allowed,
   // drive samples, one record per sample_stb
   input  wire         sample_stb,
   input  wire [15:0]  drive_status,
   input  wire [15:0]  protections,
   input  wire [15:0]  logic_io,
   input  wire [47:0]  aux_values,
   input  wire [15:0]  speed_ref,
   input  wire [15:0]  speed_fbk,
   input  wire [15:0]  arm_current_ref,
   input  wire [15:0]  arm_current_fbk,
   input  wire [15:0]  armature_voltage_sample,
   input  wire [15:0]  flux,
   input  wire [15:0]  field_current_ref,
   input  wire [15:0]  field_current_fbk,
   input  wire [15:0]  line_voltage,
   input  wire [15:0]  firing_angle,
   // thyristor samples
   input  wire         thy_sample_stb,
   input  wire [7:0]   thyristor_number,
   // trip and configuration
   input  wire         trip,
   input  wire         trace_rearm,
   input  wire [5:0]   drive_trace_post_trip_count,
   input  wire [5:0]   thyristor_trace_post_trip_count,
   // response words
   output reg  [15:0]  rsp_op,
   output reg  [15:0]  rsp_index,
   output reg  [15:0]  rsp_value,
   output reg          rsp_stb
);
   localparam S_IDLE = 2'h0;
   localparam S_WAIT = 2'h1;
   localparam S_DONE = 2'h2;
   reg  [1:0]   state_reg;
   reg  [15:0]  op_reg;
   reg  [15:0]  idx_reg;
   reg          err_hold_reg;
   reg  [7:0]   seq_reg;
   reg  [7:0]   ref_seq_reg;
   reg          ref_lock_reg;
   reg          trip_pend_reg;
   wire         smp_take = sample_stb && !trace_rearm;
   wire [3:0]   cmd = op_reg[`CMD_HI:`CMD_LO];
   wire [7:0]   rec = idx_reg[15:8];
   wire [7:0]   fld = idx_reg[7:0];
   wire [15:0]  drv_data;
   wire [15:0]  thy_data;
   wire         drv_rec_bad = (rec >= `DRV_RECORDS);
   wire         thy_rec_bad = (rec >= `THY_RECORDS);
   wire         drv_fld_bad = (fld >= `DRV_FIELDS);
   wire         thy_fld_bad = (fld >= `THY_FIELDS);
   // ----------------------------------------
   // relative record numbers
   // ----------------------------------------
   // drive records keep a running sample count, made relative on read, so older
   // records come out negative without rewriting the memory
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         seq_reg       <= 8'h00;
         ref_seq_reg   <= 8'h00;
         ref_lock_reg  <= 1'b0;
         trip_pend_reg <= 1'b0;
      end else begin
         // same trip bookkeeping as the drive trace store
         trip_pend_reg <= (trip || trip_pend_reg) && !(smp_take && !ref_lock_reg) &&
                          !(trace_rearm && !trip);
         if (sample_stb)
            seq_reg <= seq_reg + 8'h01;
         if (trace_rearm)
            ref_lock_reg <= 1'b0;
         else if (smp_take && !ref_lock_reg) begin
            // untripped, the newest record reads as number zero
            ref_seq_reg  <= seq_reg;
            ref_lock_reg <= trip || trip_pend_reg;
         end
      end
   end
   wire [255:0] drv_sample = {firing_angle, line_voltage, field_current_fbk,
                              field_current_ref, flux, armature_voltage_sample,
                              arm_current_fbk, arm_current_ref, speed_fbk,
                              speed_ref, aux_values, logic_io, protections,
                              drive_status[7:0], seq_reg};
   wire [79:0]  thy_sample = {protections, drive_status[7:0], thyristor_number,
                              firing_angle, arm_current_fbk,
                              arm_current_ref};
   trace_store #(
      .RECORDS (`DRV_RECORDS),
      .FIELDS  (`DRV_FIELDS),
      .AW      (6)
   ) u_drive_trace (
      .mclk            (mclk),
      .rst_b           (rst_b),
      .sample_stb      (sample_stb),
      .sample_data     (drv_sample),
      .trip            (trip),
      .post_trip_count (drive_trace_post_trip_count),
      .rearm           (trace_rearm),
      .rd_offset       (rec[5:0]),
      .rd_field        (fld[4:0]),
      .rd_data         (drv_data),
      .rd_wptr         (),
      .tripped         ()
   );
   trace_store #(
      .RECORDS (`THY_RECORDS),
      .FIELDS  (`THY_FIELDS),
      .AW      (6)
   ) u_thy_trace (
      .mclk            (mclk),
      .rst_b           (rst_b),
      .sample_stb      (thy_sample_stb),
      .sample_data     (thy_sample),
      .trip            (trip),
      .post_trip_count (thyristor_trace_post_trip_count),
      .rearm           (trace_rearm),
      .rd_offset       (rec[5:0]),
      .rd_field        (fld[4:0]),
      .rd_data         (thy_data),
      .rd_wptr         (),
      .tripped         ()
   );
   // ----------------------------------------
   // request handling
   // ----------------------------------------
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= S_IDLE;
         op_reg       <= 16'h0000;
         idx_reg      <= 16'h0000;
         err_hold_reg <= 1'b0;
         param_addr   <= 16'h0000;
         rsp_op       <= 16'h0000;
         rsp_index    <= 16'h0000;
         rsp_value    <= 16'h0000;
         rsp_stb      <= 1'b0;
      end else begin
         rsp_stb <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (req_stb) begin
                  op_reg     <= req_op;
                  idx_reg    <= req_index;
                  param_addr <= req_index;
                  state_reg  <= S_WAIT;
               end
            end
            // one cycle for trace memory and parameter table to answer
            S_WAIT: state_reg <= S_DONE;
            S_DONE: begin
               state_reg <= S_IDLE;
               rsp_stb   <= 1'b1;
               rsp_index <= idx_reg;
               if (cmd == `CMD_DRIVE_TRACE || cmd == `CMD_THY_TRACE) begin
                  if ((cmd == `CMD_DRIVE_TRACE && (drv_rec_bad || drv_fld_bad)) ||
                      (cmd == `CMD_THY_TRACE && (thy_rec_bad || thy_fld_bad))) begin
                     rsp_op       <= op_reg | 16'h0004;
                     rsp_value    <= `ERR_OUT_OF_RANGE;
                     err_hold_reg <= 1'b1;
                  end else begin
                     rsp_op       <= op_reg;
                     if (cmd == `CMD_THY_TRACE)
                        rsp_value <= thy_data;
                     else if (fld == 8'h00)
                        rsp_value <= {drv_data[15:8], drv_data[7:0] - ref_seq_reg};
                     else
                        rsp_value <= drv_data;
                     err_hold_reg <= 1'b0;
                  end
               end else if (cmd == `CMD_PARAM_READ) begin
                  if (!param_exists || idx_reg >= PARAMS) begin
                     rsp_op       <= op_reg | 16'h0004;
                     rsp_value    <= `ERR_NOT_EXIST;
                     err_hold_reg <= 1'b1;
                  end else if (!param_bus_allowed) begin
                     rsp_op       <= op_reg | 16'h0004;
                     rsp_value    <= `ERR_NOT_ALLOWED;
                     err_hold_reg <= 1'b1;
                  end else begin
                     // type in 15..12, negated in 11, conversion in 9..8
                     rsp_op       <= {param_type, param_negated, 1'b0, param_conv,
                                      op_reg[7:3], 1'b0, op_reg[1:0]};
                     rsp_value    <= param_value;
                     err_hold_reg <= 1'b0;
                  end
               end else begin
                  rsp_op       <= op_reg | 16'h0004;
                  rsp_value    <= `ERR_CONSISTENCY;
                  err_hold_reg <= 1'b1;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== sim/trace_channel_props.sv
// assertion checker for the trace parameter channel
`timescale 1ns/100ps
`default_nettype none
module trace_channel_props #(
   parameter PARAMS = 64
) (
   // clock and reset
   input wire        mclk,
   input wire        rst_b,
   // request and lookup
   input wire        req_stb,
   input wire [15:0] req_op,
   input wire [15:0] req_index,
   input wire [15:0] param_addr,
   input wire        param_exists,
   input wire        param_bus_allowed,
   input wire [1:0]  param_conv,
   // response
   input wire [15:0] rsp_op,
   input wire [15:0] rsp_index,
   input wire [15:0] rsp_value,
   input wire        rsp_stb
);
   reg  [1:0]  busy_reg;
   reg  [15:0] op_reg;
   reg  [15:0] idx_reg;
   wire        take = req_stb && busy_reg == 2'h0;
   wire [3:0]  cmd  = op_reg[7:4];
   wire [7:0]  rec  = idx_reg[15:8];
   wire [7:0]  fld  = idx_reg[7:0];
   wire        drv_ok = cmd == 4'h1 && rec < 8'h32 && fld < 8'h10;
   wire        thy_ok = cmd == 4'h2 && rec < 8'h10 && fld < 8'h05;
   // shadow of the request being served, busy for two cycles after take
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg <= 2'h0;
         op_reg   <= 16'h0000;
         idx_reg  <= 16'h0000;
      end else if (take) begin
         busy_reg <= 2'h2;
         op_reg   <= req_op;
         idx_reg  <= req_index;
      end else if (busy_reg != 2'h0) begin
         busy_reg <= busy_reg - 2'h1;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_rsp_latency: assert property (take |=> !rsp_stb ##1 !rsp_stb ##1 rsp_stb)
      else $error("response strobe not three cycles after request");
   a_rsp_pulse: assert property (rsp_stb |=> !rsp_stb)
      else $error("response strobe longer than one cycle");
   a_words_hold: assert property (!rsp_stb |-> $stable({rsp_op, rsp_index, rsp_value}))
      else $error("response words changed without a response");
   a_addr_capture: assert property (take |=> param_addr == $past(req_index))
      else $error("lookup address not the request index");
   a_op_echo: assert property (rsp_stb |-> rsp_op[7:4] == cmd && rsp_index == idx_reg)
      else $error("command or index not echoed");
   a_trace_good: assert property (rsp_stb && (drv_ok || thy_ok) |-> rsp_op == op_reg)
      else $error("good trace answer altered word one");
   a_record_range: assert property (rsp_stb && (cmd == 4'h1 && rec > 8'h31 ||
      cmd == 4'h2 && rec > 8'h0F) |-> rsp_op[2] && rsp_value == 16'h0001)
      else $error("bad record not flagged with code one");
   a_field_range: assert property (rsp_stb && (cmd == 4'h1 && rec < 8'h32 && fld > 8'h0F ||
      cmd == 4'h2 && rec < 8'h10 && fld > 8'h04) |-> rsp_op[2] && rsp_value == 16'h0001)
      else $error("bad field not flagged");
   a_param_absent: assert property (rsp_stb && cmd == 4'h6 &&
      (!$past(param_exists, 2) || idx_reg >= PARAMS)
      |-> rsp_op[2] && rsp_value == 16'h0002)
      else $error("missing parameter not flagged with code two");
   a_conv_code: assert property (rsp_stb && cmd == 4'h6 && $past(param_exists, 2) &&
      idx_reg < PARAMS &&
      $past(param_bus_allowed, 2) |-> !rsp_op[2] && rsp_op[9:8] == $past(param_conv, 2))
      else $error("conversion code not reported");
   c_drive: cover property (rsp_stb && drv_ok);
   c_thy: cover property (rsp_stb && thy_ok);
   c_param: cover property (rsp_stb && cmd == 4'h6);
endmodule
`default_nettype wire

// ===== sim/param_table_model.sv
// parameter table standing behind the lookup port
`timescale 1ns/100ps
`default_nettype none
module param_table_model (
   input  wire [15:0] param_addr,
   output wire [15:0] param_value,
   output wire [3:0]  param_type,
   output wire        param_negated,
   output wire [1:0]  param_conv,
   output wire        param_exists,
   output wire        param_bus_allowed
);
   assign param_value       = {param_addr[7:0], ~param_addr[7:0]};
   assign param_type        = param_addr[3:0];
   assign param_negated     = param_addr[4];
   // only codes 0..2 are defined, so pattern 3 folds to 0
   assign param_conv        = (param_addr[1:0] == 2'h3) ? 2'h0 : param_addr[1:0];
   assign param_exists      = param_addr < 16'h0040;
   assign param_bus_allowed = param_addr != 16'h0030;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the trace parameter channel
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic         mclk = 1'b0;
   logic         rst_b = 1'b0;
   logic         req_stb = 1'b0;
   logic [15:0]  req_op = 16'h0000;
   logic [15:0]  req_index = 16'h0000;
   logic         smp_stb = 1'b0;
   logic [255:0] rec = 256'h0;
   logic [7:0]   thy_num = 8'h00;
   logic         trip = 1'b0;
   logic         trace_rearm = 1'b0;
   logic [3:0]   tmap [0:4] = '{4'h8, 4'h9, 4'hF, 4'h0, 4'h1};
   int           mismatches = 0;
   int           cmp_count = 0;
   int           cycles = 0;
   wire [15:0]   param_addr, param_value, rsp_op, rsp_index, rsp_value;
   wire [15:0]   drive_status, protections, logic_io, speed_ref, speed_fbk, arm_current_ref;
   wire [15:0]   arm_current_fbk, armature_voltage_sample, flux, field_current_ref;
   wire [15:0]   field_current_fbk, line_voltage, firing_angle;
   wire [47:0]   aux_values;
   wire [3:0]    param_type;
   wire [1:0]    param_conv;
   wire          param_negated, param_exists, param_bus_allowed, rsp_stb;
   // field f of a sample carries f in its top nibble
   assign {firing_angle, line_voltage, field_current_fbk, field_current_ref, flux,
      armature_voltage_sample, arm_current_fbk, arm_current_ref, speed_fbk, speed_ref,
      aux_values, logic_io, protections, drive_status} = rec;
   always #2 mclk = ~mclk;
   fieldbus_trace_param_channel i_fieldbus_trace_param_channel (.mclk(mclk), .rst_b(rst_b),
      .req_stb(req_stb), .req_op(req_op), .req_index(req_index), .param_addr(param_addr),
      .param_value(param_value), .param_type(param_type), .param_negated(param_negated),
      .param_conv(param_conv), .param_exists(param_exists),
      .param_bus_allowed(param_bus_allowed), .sample_stb(smp_stb),
      .drive_status(drive_status), .protections(protections), .logic_io(logic_io),
      .aux_values(aux_values), .speed_ref(speed_ref), .speed_fbk(speed_fbk),
      .arm_current_ref(arm_current_ref), .arm_current_fbk(arm_current_fbk),
      .armature_voltage_sample(armature_voltage_sample), .flux(flux),
      .field_current_ref(field_current_ref), .field_current_fbk(field_current_fbk),
      .line_voltage(line_voltage), .firing_angle(firing_angle), .thy_sample_stb(smp_stb),
      .thyristor_number(thy_num), .trip(trip), .trace_rearm(trace_rearm),
      .drive_trace_post_trip_count(6'h05), .thyristor_trace_post_trip_count(6'h05),
      .rsp_op(rsp_op), .rsp_index(rsp_index), .rsp_value(rsp_value), .rsp_stb(rsp_stb));
   param_table_model i_param_table_model (.param_addr(param_addr), .param_value(param_value),
      .param_type(param_type), .param_negated(param_negated), .param_conv(param_conv),
      .param_exists(param_exists), .param_bus_allowed(param_bus_allowed));
   function [15:0] fv(input [3:0] f, input [11:0] i);
      fv = {f, i};
   endfunction
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task xfer(input [15:0] op, input [15:0] idx);
      int n;
      @(posedge mclk);
      req_stb <= 1'b1;
      req_op <= op;
      req_index <= idx;
      @(posedge mclk);
      req_stb <= 1'b0;
      n = 0;
      // poll on the falling edge, clear of the edge that moves the strobe
      while (rsp_stb !== 1'b1 && n < 8) begin
         @(negedge mclk);
         n++;
      end
      check({15'h0000, rsp_stb}, 16'h0001);
   endtask
   task tr(input [15:0] op, input [15:0] idx, input logic err, input [15:0] v);
      xfer(op, idx);
      check(rsp_op, op | {13'h0000, err, 2'h0});
      check(rsp_index, idx);
      check(rsp_value, v);
   endtask
   task samp(input [11:0] i);
      @(posedge mclk);
      for (int f = 0; f < 16; f++) rec[f*16+:16] <= fv(f, i);
      thy_num <= i[7:0] + 8'h40;
      smp_stb <= 1'b1;
      @(posedge mclk);
      smp_stb <= 1'b0;
   endtask
   // ----------------------------------------
   // scenarios, after 60 samples so both traces have wrapped
   // ----------------------------------------
   task t_drive;
      logic [11:0] i;
      for (int r = 0; r < 50; r += 49)
         for (int f = 0; f < 16; f++) begin
            i = 12'h00A + r;
            tr(16'h0012, {r[7:0], f[7:0]}, 1'b0,
               f == 0 ? {i[7:0], r[7:0] - 8'h31} : fv(f, i));
         end
   endtask
   task t_thy;
      logic [11:0] i;
      for (int r = 0; r < 16; r += 15)
         for (int f = 0; f < 5; f++) begin
            i = 12'h02C + r;
            tr(16'h0022, {r[7:0], f[7:0]}, 1'b0,
               f == 3 ? {i[7:0], i[7:0] + 8'h40} : fv(tmap[f], i));
         end
   endtask
   task t_errors;
      tr(16'h0012, 16'h3200, 1'b1, 16'h0001);
      tr(16'h0022, 16'h1000, 1'b1, 16'h0001);
      tr(16'h0012, 16'h3110, 1'b1, 16'h0001);
      tr(16'h0022, 16'h0F05, 1'b1, 16'h0001);
      tr(16'h0052, 16'h0000, 1'b1, 16'h0003);
      tr(16'h0012, 16'h0006, 1'b0, fv(4'h6, 12'h00A));
   endtask
   task t_param;
      logic [15:0] a;
      for (int k = 0; k < 3; k++) begin
         a = k == 0 ? 16'h0014 : (k == 1 ? 16'h0029 : 16'h000E);
         xfer(16'h0060, a);
         check(rsp_op & 16'hFBFF, {a[3:0], a[4], 1'b0, k[1:0], 8'h60});
         check(rsp_index, a);
         check(rsp_value, {a[7:0], ~a[7:0]});
      end
      xfer(16'h0060, 16'h0040);
      check({8'h00, rsp_op[7:0]}, 16'h0064);
      check(rsp_value, 16'h0002);
      xfer(16'h0060, 16'h0030);
      check(rsp_value, 16'h0004);
   endtask
   // trip pulse between samples, five post-trip records, then rearm
   task t_trip;
      @(posedge mclk);
      trip <= 1'b1;
      @(posedge mclk);
      trip <= 1'b0;
      for (int i = 100; i < 108; i++) samp(i);
      tr(16'h0012, 16'h0000, 1'b0, 16'h10D4);
      tr(16'h0012, 16'h2C00, 1'b0, 16'h6400);
      tr(16'h0012, 16'h3100, 1'b0, 16'h6905);
      tr(16'h0012, 16'h3106, 1'b0, fv(4'h6, 12'h069));
      tr(16'h0022, 16'h0F02, 1'b0, fv(4'hF, 12'h069));
      tr(16'h0022, 16'h0A03, 1'b0, 16'h64A4);
      @(posedge mclk);
      trace_rearm <= 1'b1;
      @(posedge mclk);
      trace_rearm <= 1'b0;
      samp(108);
      tr(16'h0012, 16'h3100, 1'b0, 16'h6C00);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 60; i++) samp(i);
      t_drive;
      t_thy;
      t_errors;
      t_param;
      t_trip;
      tally_and_finish;
   end
   // run takes well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         tally_and_finish;
      end
   end
endmodule
bind fieldbus_trace_param_channel trace_channel_props #(.PARAMS(PARAMS)) i_trace_channel_props (
   .mclk(mclk), .rst_b(rst_b), .req_stb(req_stb), .req_op(req_op), .req_index(req_index),
   .param_addr(param_addr), .param_exists(param_exists), .param_bus_allowed(param_bus_allowed),
   .param_conv(param_conv), .rsp_op(rsp_op), .rsp_index(rsp_index), .rsp_value(rsp_value),
   .rsp_stb(rsp_stb));
`default_nettype wire
